// ### hdl/spq_pkg.sv
// Shared constants of the sequence pipeline queue: register map, fields, codes
`default_nettype none
package spq_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ       = 125000;  // 125 MHz clock
  localparam int unsigned TICK_MS       = 1;       // Timeout resolution in ms
  localparam int unsigned CYCLES_PER_MS = TICK_MS * CLK_KHZ;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MODE     = 8'h00;
  localparam logic [7:0] OFS_CTRL     = 8'h04;
  localparam logic [7:0] OFS_REPS     = 8'h08;
  localparam logic [7:0] OFS_REPS_REM = 8'h0c;
  localparam logic [7:0] OFS_TIMEOUT  = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_SLOTS    = 8'h18;
  localparam logic [7:0] OFS_IDS      = 8'h1c;
  localparam logic [7:0] OFS_STAGE    = 8'h20;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h28;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_EN_BIT     = 0;
  localparam int unsigned CTRL_COMMIT_BIT = 1;
  localparam int unsigned CTRL_RESET_BIT  = 2;
  localparam int unsigned STAT_READY_BIT  = 4;
  localparam int unsigned SLOTS_MAX_POS   = 16;
  localparam int unsigned IDS_RUN_POS     = 16;

  // ----------------------------------------------------------------
  // Modes, status codes, interrupt events, reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_BATCH = 2'h1;
  localparam logic [1:0] MODE_QUEUE = 2'h2;

  localparam logic [1:0] ST_IDLE = 2'h0;
  localparam logic [1:0] ST_EXEC = 2'h1;
  localparam logic [1:0] ST_WAIT = 2'h2;
  localparam logic [1:0] ST_DONE = 2'h3;

  localparam int unsigned IRQ_W          = 4;
  localparam int unsigned IRQ_SEQ_DONE   = 0;
  localparam int unsigned IRQ_TIMEOUT    = 1;
  localparam int unsigned IRQ_BATCH_DONE = 2;
  localparam int unsigned IRQ_STARVED    = 3;

  localparam int unsigned REPS_W   = 22;
  localparam logic [21:0] REPS_MIN = 22'h000001;
  localparam logic [21:0] REPS_MAX = 22'h3d0900;  // 4e6
  localparam int unsigned TMO_W    = 32;
  localparam logic [31:0] TMO_RST  = 32'h00000000;
endpackage
`default_nettype wire

// ### hdl/spq_queue.sv
// Sequence pipeline queue with Wishbone register file and sequencer hand-off
`timescale 1ns/100ps
`default_nettype none
module spq_queue
  import spq_pkg::*;
#(
  parameter int unsigned DEPTH     = 16,
  parameter int unsigned ID_W      = 16,
  parameter int unsigned MS_CYCLES = CYCLES_PER_MS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  input  wire logic        seq_done_i,
  output logic             seq_start_o,
  output logic      [31:0] seq_word_o,
  output logic [ID_W-1:0]  seq_id_o,
  output logic             seq_abort_o,
  output logic             seq_reset_o
);
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = PW + 1;
  localparam int unsigned MW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  initial begin
    if (DEPTH < 2 || DEPTH > 128 || (DEPTH & (DEPTH - 1)) != 0)
      $error("DEPTH must be a power of two from 2 to 128");
    if (ID_W < 1 || ID_W > 16)
      $error("ID_W must be 1 to 16");
    if (MS_CYCLES < 1)
      $error("MS_CYCLES must be at least 1");
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction
  // Out-of-range counts are pulled to the nearest legal value
  function automatic logic [REPS_W-1:0] reps_clamp(input logic [31:0] v);
    if (v == 32'h0) begin
      return REPS_MIN;
    end else if (v > {10'h000, REPS_MAX}) begin
      return REPS_MAX;
    end else begin
      return v[REPS_W-1:0];
    end
  endfunction
  typedef enum logic [4:0] {
    SPQ_IDLE   = 5'b00001,
    SPQ_LAUNCH = 5'b00010,
    SPQ_EXEC   = 5'b00100,
    SPQ_WAIT   = 5'b01000,
    SPQ_DONE   = 5'b10000
  } spq_state_t;
  function automatic logic [1:0] status_code(input spq_state_t s);
    case (s)
      SPQ_LAUNCH, SPQ_EXEC: status_code = ST_EXEC;
      SPQ_WAIT:             status_code = ST_WAIT;
      SPQ_DONE:             status_code = ST_DONE;
      default:              status_code = ST_IDLE;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // State declarations
  // ----------------------------------------------------------------
  logic [1:0]        mode_q, mode_d;
  logic              en_q, en_d;
  logic [REPS_W-1:0] reps_q, reps_d;
  logic [TMO_W-1:0]  tmo_q, tmo_d;
  logic [31:0]       stage_q, stage_d;
  logic [IRQ_W-1:0]  istat_q, istat_d;
  logic [IRQ_W-1:0]  imask_q, imask_d;
  logic              ack_q, ack_d;
  logic [31:0]       rdat_q, rdat_d;
  logic              irq_q, irq_d;
  spq_state_t        st_q, st_d;
  logic [PW-1:0]     head_q, head_d;
  logic [PW-1:0]     wptr_q, wptr_d;
  logic [CW-1:0]     cnt_q, cnt_d;
  logic [PW-1:0]     pos_q, pos_d;
  logic [REPS_W-1:0] rem_q, rem_d;
  logic [ID_W-1:0]   id_stage_q, id_stage_d;
  logic [ID_W-1:0]   id_run_q, id_run_d;
  logic [MW-1:0]     div_q, div_d;
  logic [TMO_W-1:0]  ms_q, ms_d;
  logic              start_q, start_d;
  logic              abort_q, abort_d;
  logic              sreset_q, sreset_d;
  logic [31:0]       word_q, word_d;
  logic [31:0]       mem_word [DEPTH];
  logic [ID_W-1:0]   mem_id   [DEPTH];
  logic              mem_we;
  // Decoded commands and shared status
  logic              wr_stb;
  logic              mode_chg;
  logic              cmd_commit;
  logic              cmd_reset;
  logic              ready;
  logic              commit_ok;
  logic [CW-1:0]     free_slots;
  logic [IRQ_W-1:0]  ev;

  // Write is applied on the edge where the master sees ack
  assign wr_stb     = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
  assign mode_chg   = wr_stb && wb_adr_i == OFS_MODE && wb_sel_i[0] &&
                      wb_dat_i[1:0] != mode_q && wb_dat_i[1:0] != 2'h3;
  assign cmd_commit = wr_stb && wb_adr_i == OFS_CTRL && wb_sel_i[0] &&
                      wb_dat_i[CTRL_COMMIT_BIT];
  assign cmd_reset  = wr_stb && wb_adr_i == OFS_CTRL && wb_sel_i[0] &&
                      wb_dat_i[CTRL_RESET_BIT];
  assign free_slots = DEPTH_C - cnt_q;
  // Batch takes no commits once enabled, since the batch is fixed
  assign ready      = free_slots != '0 && mode_q != MODE_OFF &&
                      (mode_q == MODE_QUEUE || !en_q);
  assign commit_ok  = cmd_commit && ready && !mode_chg && !cmd_reset;
  // ----------------------------------------------------------------
  // Register file and Wishbone slave
  // ----------------------------------------------------------------
  // Next values of software-visible registers and the bus answer
  always_comb begin
    mode_d  = mode_q;
    en_d    = en_q;
    reps_d  = reps_q;
    tmo_d   = tmo_q;
    stage_d = stage_q;
    imask_d = imask_q;
    istat_d = istat_q;
    ack_d   = wb_cyc_i & wb_stb_i & ~ack_q;
    rdat_d  = rdat_q;
    if (wr_stb) begin
      case (wb_adr_i)
        OFS_MODE: begin
          if (wb_sel_i[0] && wb_dat_i[1:0] != 2'h3) begin
            mode_d = wb_dat_i[1:0];
          end
        end
        OFS_CTRL: begin
          if (wb_sel_i[0]) begin
            en_d = wb_dat_i[CTRL_EN_BIT];
          end
        end
        OFS_REPS:     reps_d  = reps_clamp(lane_merge({10'h000, reps_q}, wb_dat_i,
                                                      wb_sel_i));
        OFS_TIMEOUT:  tmo_d   = lane_merge(tmo_q, wb_dat_i, wb_sel_i);
        OFS_STAGE:    stage_d = lane_merge(stage_q, wb_dat_i, wb_sel_i);
        OFS_IRQ_MASK: imask_d = wb_sel_i[0] ? wb_dat_i[IRQ_W-1:0] : imask_q;
        OFS_IRQ_STAT: istat_d = istat_q & ~(wb_dat_i[IRQ_W-1:0] & {IRQ_W{wb_sel_i[0]}});
        default: ;
      endcase
    end
    // Mode change and reset command both drop enable
    if (mode_chg || cmd_reset) begin
      en_d = 1'b0;
    end
    if (mode_d != MODE_BATCH) begin
      reps_d = REPS_MIN;
    end
    // Hardware set wins over a same-cycle clear
    istat_d = istat_d | ev;
    irq_d   = |(istat_d & imask_d);
    if (ack_d) begin
      case (wb_adr_i)
        OFS_MODE:     rdat_d = {30'h0, mode_q};
        OFS_CTRL:     rdat_d = {31'h0, en_q};
        OFS_REPS:     rdat_d = {10'h000, reps_q};
        OFS_REPS_REM: rdat_d = {10'h000, rem_q};
        OFS_TIMEOUT:  rdat_d = tmo_q;
        OFS_STATUS:   rdat_d = {27'h0, ready, 2'h0, status_code(st_q)};
        OFS_SLOTS:    rdat_d = {8'h00, 8'(DEPTH), 8'h00, 8'(free_slots)};
        OFS_IDS:      rdat_d = {16'(id_run_q), 16'(id_stage_q)};
        OFS_STAGE:    rdat_d = stage_q;
        OFS_IRQ_STAT: rdat_d = {28'h0, istat_q};
        OFS_IRQ_MASK: rdat_d = {28'h0, imask_q};
        default:      rdat_d = 32'h0;
      endcase
    end
  end
  // Register file flops; grouped, since most of them reset to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= MODE_OFF;
      reps_q <= REPS_MIN;
      tmo_q  <= TMO_RST;
      {en_q, stage_q, imask_q, istat_q, ack_q, rdat_q, irq_q} <= '0;
    end else begin
      {mode_q, en_q, reps_q, tmo_q, stage_q} <= {mode_d, en_d, reps_d, tmo_d, stage_d};
      {imask_q, istat_q, ack_q, rdat_q, irq_q} <= {imask_d, istat_d, ack_d, rdat_d, irq_d};
    end
  end
  // ----------------------------------------------------------------
  // Queue control and sequencer hand-off
  // ----------------------------------------------------------------
  // Next state of the slot pointers, run control and timeout timer
  always_comb begin
    logic [PW-1:0] idx;
    logic          pop;
    logic          fin;
    logic          tmo_hit;
    logic [CW-1:0] cnt_after;
    idx        = '0;
    pop        = 1'b0;
    fin        = 1'b0;
    tmo_hit    = 1'b0;
    cnt_after  = '0;
    st_d       = st_q;
    head_d     = head_q;
    wptr_d     = wptr_q;
    cnt_d      = cnt_q;
    pos_d      = pos_q;
    rem_d      = rem_q;
    id_stage_d = id_stage_q;
    id_run_d   = id_run_q;
    div_d      = div_q;
    ms_d       = ms_q;
    start_d    = 1'b0;
    abort_d    = 1'b0;
    sreset_d   = 1'b0;
    word_d     = word_q;
    mem_we     = 1'b0;
    ev         = '0;
    idx        = (mode_q == MODE_BATCH) ? PW'(head_q + pos_q) : head_q;
    if (mode_chg || cmd_reset) begin
      // Drop every slot; a running sequence is stopped as well
      sreset_d = mode_chg;
      abort_d  = cmd_reset && st_q == SPQ_EXEC;
      st_d     = SPQ_IDLE;
      head_d   = '0;
      wptr_d   = '0;
      cnt_d    = '0;
      pos_d    = '0;
    end else begin
      if (commit_ok) begin
        mem_we     = 1'b1;
        wptr_d     = PW'(wptr_q + 1'b1);
        id_stage_d = ID_W'(id_stage_q + 1'b1);
      end
      // Millisecond timer runs only while a sequence executes
      if (st_q == SPQ_EXEC) begin
        if (div_q == MW'(MS_CYCLES - 1)) begin
          div_d = '0;
          ms_d  = TMO_W'(ms_q + 1'b1);
        end else begin
          div_d = MW'(div_q + 1'b1);
        end
      end
      tmo_hit = tmo_q != '0 && ms_q >= tmo_q;
      case (st_q)
        SPQ_IDLE: begin
          if (en_q && mode_q != MODE_OFF) begin
            pos_d = '0;
            rem_d = reps_q;
            if (cnt_q != '0) begin
              st_d = SPQ_LAUNCH;
            end else if (mode_q == MODE_QUEUE) begin
              st_d = SPQ_WAIT;
            end else begin
              st_d = SPQ_DONE;
            end
          end
        end
        SPQ_LAUNCH: begin
          start_d  = 1'b1;
          word_d   = mem_word[idx];
          id_run_d = mem_id[idx];
          div_d    = '0;
          ms_d     = '0;
          st_d     = SPQ_EXEC;
        end
        SPQ_EXEC: begin
          if (seq_done_i || tmo_hit) begin
            fin = 1'b1;
            abort_d = tmo_hit && !seq_done_i;
            ev[IRQ_TIMEOUT]  = tmo_hit && !seq_done_i;
            ev[IRQ_SEQ_DONE] = 1'b1;
          end
        end
        SPQ_WAIT: begin
          if (!en_q) begin
            st_d = SPQ_IDLE;
          end else if (cnt_q != '0) begin
            st_d = SPQ_LAUNCH;
          end
        end
        SPQ_DONE: begin
          if (!en_q) begin
            st_d = SPQ_IDLE;
          end
        end
        default: st_d = SPQ_IDLE;
      endcase
      // End of one sequence: free the slot or step through the batch
      if (fin) begin
        if (mode_q == MODE_QUEUE) begin
          pop    = 1'b1;
          head_d = PW'(head_q + 1'b1);
        end
        cnt_after = CW'(cnt_q + CW'(commit_ok) - CW'(pop));
        if (!en_q) begin
          st_d = SPQ_IDLE;
        end else if (mode_q == MODE_QUEUE) begin
          st_d = (cnt_after != '0) ? SPQ_LAUNCH : SPQ_WAIT;
          ev[IRQ_STARVED] = cnt_after == '0;
        end else if (CW'(pos_q) + 1'b1 < cnt_q) begin
          pos_d = PW'(pos_q + 1'b1);
          st_d  = SPQ_LAUNCH;
        end else if (rem_q > REPS_MIN) begin
          rem_d = REPS_W'(rem_q - 1'b1);
          pos_d = '0;
          st_d  = SPQ_LAUNCH;
        end else begin
          rem_d = '0;
          st_d  = SPQ_DONE;
          ev[IRQ_BATCH_DONE] = 1'b1;
        end
      end
      cnt_d = CW'(cnt_q + CW'(commit_ok) - CW'(pop));
    end
    if (mode_q != MODE_BATCH) begin
      rem_d = REPS_MIN;
    end
  end
  // Queue control flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q  <= SPQ_IDLE;
      rem_q <= REPS_MIN;
      {head_q, wptr_q, cnt_q, pos_q, id_stage_q, id_run_q} <= '0;
      {div_q, ms_q, start_q, abort_q, sreset_q, word_q} <= '0;
    end else begin
      st_q <= st_d;
      {head_q, wptr_q, cnt_q, pos_q, rem_q} <= {head_d, wptr_d, cnt_d, pos_d, rem_d};
      {id_stage_q, id_run_q, div_q, ms_q} <= {id_stage_d, id_run_d, div_d, ms_d};
      {start_q, abort_q, sreset_q, word_q} <= {start_d, abort_d, sreset_d, word_d};
    end
  end
  // Slot storage; no reset needed, occupancy is tracked by the count
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem_word[wptr_q] <= stage_q;
      mem_id[wptr_q]   <= id_stage_q;
    end
  end
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o    = ack_q;
  assign wb_dat_o    = rdat_q;
  assign irq_o       = irq_q;
  assign seq_start_o = start_q;
  assign seq_word_o  = word_q;
  assign seq_id_o    = id_run_q;
  assign seq_abort_o = abort_q;
  assign seq_reset_o = sreset_q;
endmodule
`default_nettype wire

// ### sim/spq_seq_model.sv
// Behavioural waveform sequencer on the far side of the queue
`timescale 1ns/100ps
`default_nettype none
module spq_seq_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic [31:0] word_i,
  input  wire logic        stop_i,
  output logic             done_o
);
  logic [7:0] cnt_q;
  logic       busy_q;
  logic       hang_q;
  // Low byte sets the run length; bit 15 runs until aborted, for timeout cases
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i || stop_i) begin
      busy_q <= 1'b0;
    end else if (start_i) begin
      busy_q <= 1'b1;
      cnt_q  <= word_i[7:0];
      hang_q <= word_i[15];
    end else if (busy_q && !hang_q) begin
      if (cnt_q == 8'h00) begin
        done_o <= 1'b1;
        busy_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/spq_queue_asserts.sv
// Port-level assertions for the sequence pipeline queue
`timescale 1ns/100ps
`default_nettype none
module spq_queue_asserts
  import spq_pkg::*;
#(
  parameter int unsigned ID_W = 16
) (
  input wire logic            clk_i,
  input wire logic            rst_i,
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic            wb_we_i,
  input wire logic [7:0]      wb_adr_i,
  input wire logic            wb_ack_o,
  input wire logic            seq_done_i,
  input wire logic            seq_start_o,
  input wire logic [31:0]     seq_word_o,
  input wire logic [ID_W-1:0] seq_id_o,
  input wire logic            seq_abort_o,
  input wire logic            seq_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic mode_wr;
  // Acked write to the mode register, the only legal cause of a sequencer reset
  assign mode_wr = wb_cyc_i && wb_we_i && wb_ack_o && (wb_adr_i == OFS_MODE);

  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  property p_start_pulse;
    seq_start_o |=> !seq_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_abort_pulse;
    seq_abort_o |=> !seq_abort_o;
  endproperty
  a_abort_pulse: assert property (p_abort_pulse) else $error("abort too long");
  property p_reset_cause;
    seq_reset_o |-> $past(mode_wr) || $past(mode_wr, 2);
  endproperty
  a_reset_cause: assert property (p_reset_cause) else $error("stray seq reset");
  property p_hold;
    !seq_start_o |-> $stable(seq_id_o) && $stable(seq_word_o);
  endproperty
  a_hold: assert property (p_hold) else $error("word or id moved");
  property p_done_gap;
    seq_done_i |=> !seq_start_o;
  endproperty
  a_done_gap: assert property (p_done_gap) else $error("start too soon");
  property p_start_abort;
    seq_start_o |-> !seq_abort_o;
  endproperty
  a_start_abort: assert property (p_start_abort) else $error("start with abort");
endmodule
bind spq_queue spq_queue_asserts #(.ID_W(ID_W)) spq_queue_asserts_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .seq_done_i(seq_done_i),
  .seq_start_o(seq_start_o), .seq_word_o(seq_word_o), .seq_id_o(seq_id_o),
  .seq_abort_o(seq_abort_o), .seq_reset_o(seq_reset_o));
`default_nettype wire

// ### sim/tb_sequence_pipeline_queue.sv
// Self-checking bench for the sequence pipeline queue
`timescale 1ns/100ps
`default_nettype none
module tb_sequence_pipeline_queue
  import spq_pkg::*;
();
  localparam int unsigned DEPTH = 4;
  localparam int unsigned MSC   = 10;  // Short millisecond keeps timeouts cheap
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, seq_word_o, rdv;
  logic [15:0] seq_id_o;
  logic wb_ack_o, irq_o, seq_done_i, seq_start_o, seq_abort_o, seq_reset_o;
  int n_fail = 0;
  int samples_checked = 0;
  int n_ab = 0;
  int n_sr = 0;
  int nid = 0;
  logic [31:0] wq[$];
  logic [15:0] iq[$];

  always #4 clk_i = ~clk_i;
  spq_queue #(.DEPTH(DEPTH), .ID_W(16), .MS_CYCLES(MSC)) spq_queue_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .seq_done_i(seq_done_i),
    .seq_start_o(seq_start_o), .seq_word_o(seq_word_o), .seq_id_o(seq_id_o),
    .seq_abort_o(seq_abort_o), .seq_reset_o(seq_reset_o));
  spq_seq_model spq_seq_model_inst (.clk_i(clk_i), .rst_i(rst_i), .start_i(seq_start_o),
    .word_i(seq_word_o), .stop_i(seq_abort_o || seq_reset_o), .done_o(seq_done_i));

  // Log starts and pulses as they leave the block
  always @(posedge clk_i) begin
    if (seq_start_o === 1'b1) begin
      wq.push_back(seq_word_o);
      iq.push_back(seq_id_o);
    end
    if (seq_abort_o === 1'b1) n_ab++;
    if (seq_reset_o === 1'b1) n_sr++;
  end

  task automatic results();
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hang(input string nm);
    chk(nm, 32'h1, 32'h0);
    results();
  endtask
  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (i = 0; i < 16; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    if (i == 16) hang("ack");
    rdv = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e, rdv);
  endtask
  // Status settles after the far side finishes, so poll it a bounded number of times
  task automatic poll(input logic [7:0] a, input logic [31:0] e, input string nm);
    for (int i = 0; i < 60; i++) begin
      wb(1'b0, a, 32'h0);
      if (rdv === e) break;
    end
    chk(nm, e, rdv);
  endtask
  task automatic stage(input logic [31:0] w, input logic en);
    wb(1'b1, OFS_STAGE, w);
    wb(1'b1, OFS_CTRL, {30'h0, 1'b1, en});
  endtask
  task automatic wstart(input int n);
    int i;
    for (i = 0; i < 400 && wq.size() < n; i++) @(posedge clk_i);
    if (wq.size() < n) hang("start");
  endtask

  task automatic t_defaults();
    rd(OFS_MODE, 32'h0, "mode");
    rd(OFS_REPS, 32'h1, "reps");
    rd(OFS_REPS_REM, 32'h1, "reps_rem");
    rd(OFS_STATUS, 32'h0, "status");
    rd(OFS_SLOTS, 32'(DEPTH * 65537), "slots");
    wb(1'b1, 8'h3c, 32'hffffffff);
    rd(8'h3c, 32'h0, "unmapped");
  endtask
  task automatic t_queue();
    wb(1'b1, OFS_MODE, 32'h2);
    repeat (2) @(posedge clk_i);  // Pulse leaves on the edge where the write lands; it is logged one edge later
    chk("seq_reset", 32'h1, 32'(n_sr));
    rd(OFS_STATUS, 32'h10, "ready");
    wb(1'b1, OFS_IRQ_MASK, 32'hf);
    for (int i = 0; i < 3; i++) begin
      stage(32'h100 + 32'(i * 4 + 2), 1'b0);
      nid++;
      rd(OFS_IDS, 32'(nid), "stage_id");
    end
    rd(OFS_SLOTS, 32'(DEPTH * 65536 + DEPTH - 3), "free");
    chk("idle_start", 32'h0, 32'(wq.size()));
    wb(1'b1, OFS_CTRL, 32'h1);
    wstart(3);
    for (int i = 0; i < 3; i++) begin
      chk("word", 32'h100 + 32'(i * 4 + 2), wq[i]);
      chk("run_id", 32'(i), 32'(iq[i]));
    end
    poll(OFS_STATUS, 32'h12, "wait");
    rd(OFS_SLOTS, 32'(DEPTH * 65537), "freed");
    chk("irq_set", 32'h1, 32'(irq_o));
    wb(1'b1, OFS_IRQ_STAT, 32'hf);
    rd(OFS_IRQ_STAT, 32'h0, "irq_clr");
    chk("irq_low", 32'h0, 32'(irq_o));
    wb(1'b1, OFS_IRQ_MASK, 32'h0);
    stage(32'h200, 1'b1);
    nid++;
    wstart(4);
    chk("live_id", 32'h3, 32'(iq[3]));
    poll(OFS_IRQ_STAT, 32'h9, "irq_stat");
    chk("irq_mask", 32'h0, 32'(irq_o));
  endtask
  task automatic t_fill();
    wb(1'b1, OFS_CTRL, 32'h0);
    for (int i = 0; i < DEPTH; i++) begin
      stage(32'h300, 1'b0);
      nid++;
    end
    rd(OFS_SLOTS, 32'(DEPTH * 65536), "full");
    rd(OFS_STATUS, 32'h0, "not_ready");
    stage(32'h300, 1'b0);
    rd(OFS_IDS, 32'h30000 + 32'(nid), "refused");
    wb(1'b1, OFS_CTRL, 32'h4);
    rd(OFS_SLOTS, 32'(DEPTH * 65537), "flushed");
  endtask
  task automatic t_batch();
    wq.delete();
    wb(1'b1, OFS_MODE, 32'h1);
    wb(1'b1, OFS_REPS, 32'h0);
    rd(OFS_REPS, 32'h1, "reps_min");
    wb(1'b1, OFS_REPS, 32'h7fffff);
    rd(OFS_REPS, 32'h3d0900, "reps_max");
    wb(1'b1, OFS_REPS, 32'h2);
    stage(32'h12340003, 1'b0);
    stage(32'h56780005, 1'b0);
    wb(1'b1, OFS_CTRL, 32'h1);
    wstart(4);
    poll(OFS_STATUS, 32'h3, "done");
    for (int i = 0; i < 4; i++) chk("batch_word", i[0] ? 32'h56780005 : 32'h12340003, wq[i]);
    rd(OFS_REPS_REM, 32'h0, "rem_end");
    wb(1'b1, OFS_MODE, 32'h2);
    rd(OFS_REPS, 32'h1, "reps_fixed");
    rd(OFS_REPS_REM, 32'h1, "rem_fixed");
    rd(OFS_STATUS, 32'h10, "mode_flush");
  endtask
  task automatic t_timeout();
    int a0;
    int i;
    wq.delete();
    wb(1'b1, OFS_TIMEOUT, 32'h2);
    stage(32'h8000, 1'b1);
    wstart(1);
    a0 = n_ab;
    for (i = 0; i < 100 && n_ab == a0; i++) @(posedge clk_i);
    chk("tmo_time", 32'h1, 32'(i >= MSC && i <= 3 * MSC));
    wb(1'b1, OFS_TIMEOUT, 32'h0);
    stage(32'h8000, 1'b1);
    wstart(2);
    repeat (8 * MSC) @(posedge clk_i);
    chk("no_abort", 32'(a0 + 1), 32'(n_ab));
    rd(OFS_STATUS, 32'h11, "exec");
    wb(1'b1, OFS_CTRL, 32'h4);
    rd(OFS_CTRL, 32'h0, "en_off");
    chk("rst_abort", 32'(a0 + 2), 32'(n_ab));
    wb(1'b1, OFS_MODE, 32'h3);
    rd(OFS_MODE, 32'h2, "mode_3");
    chk("mode_3_quiet", 32'h3, 32'(n_sr));
    wb(1'b1, OFS_MODE, 32'h0);
    rd(OFS_STATUS, 32'h0, "off");
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_defaults();
    t_queue();
    t_fill();
    t_batch();
    t_timeout();
    results();
  end
endmodule
`default_nettype wire
